// ---- hdl/atb_defines.svh ----
// Register offsets, field positions, reset values and timing counts for the tracking control
`ifndef ATB_DEFINES_SVH
`define ATB_DEFINES_SVH
`define ATB_TRACK_CTRL_ADDR   8'hBA
`define ATB_GAIN_ADDR         8'hBB
`define ATB_TRACK_CTRL_RESET  8'hFF
`define ATB_GAIN_RESET        8'hFF
`define ATB_PWR_MSB           7
`define ATB_PWR_LSB           4
`define ATB_TM_MSB            3
`define ATB_TM_LSB            2
`define ATB_TK_MSB            1
`define ATB_TK_LSB            0
`define ATB_PWR_STEP_NS       200
`define ATB_CLK_PERIOD_NS     8
`define ATB_PWR_STEP_CYC      ((`ATB_PWR_STEP_NS + `ATB_CLK_PERIOD_NS - 1) / `ATB_CLK_PERIOD_NS)
`define ATB_POST_SYS_CYC      2
`endif

// ---- hdl/atb_pkg.sv ----
// Types shared by the tracking and burst power control
package atb_pkg;
  typedef enum logic [1:0] {
    ATB_TM_RESERVED,
    ATB_TM_POST,
    ATB_TM_PRE,
    ATB_TM_DUAL
  } atb_track_mode_t;

  typedef enum {
    ATB_ST_IDLE,
    ATB_ST_POWERUP,
    ATB_ST_PRETRACK,
    ATB_ST_CONVERT,
    ATB_ST_POST_SAR,
    ATB_ST_POST_SYS
  } atb_state_t;

  typedef struct packed {
    logic [7:0]  track_ctrl;
    logic [7:0]  gain;
    atb_state_t  state;
    logic [11:0] count;
    logic [7:0]  rdata;
    logic        powered;
    logic        tracking;
    logic        conv_go;
  } atb_regs_t;
endpackage

// ---- hdl/atb_control.sv ----
// Tracking mode, post-track timing and burst power sequencing for the SAR converter
`default_nettype none
`include "atb_defines.svh"

// Functional notes
// - Software gain byte, 0 to 1.016 full scale, drives the converter gain.
// - Burst off: converter power follows the converter enable bit only.
// - Burst on and enabled: converter stays powered between conversions.
// - Burst on, not enabled: low power after conversion, power up on start.
// - Burst power-up delay is (field + 1) times 200 ns before tracking.
// - Tracking mode code: 00 reserved, 01 post, 10 pre, 11 dual.
// - Post-track time: 2, 4, 8 or 16 SAR clocks plus 2 system clocks.
module atb_control #(
  parameter int PWR_STEP_CYC = `ATB_PWR_STEP_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       converter_enable,
  input  wire logic       burst_mode_enable,
  input  wire logic       conv_start,
  input  wire logic       sar_clk_tick,
  input  wire logic       conv_done,
  output logic            converter_powered,
  output logic            tracking_active,
  output logic            conversion_go,
  output logic            sequence_busy,
  output logic      [7:0] gain_value
);
  import atb_pkg::*;

  atb_regs_t r_reg;
  atb_regs_t r_next;

  logic [3:0] pwr_field;
  logic [1:0] tk_field;
  atb_track_mode_t tm_field;
  logic [11:0] pwr_cycles;
  logic [4:0]  post_sar;
  logic        keep_on;

  assign pwr_field = r_reg.track_ctrl[`ATB_PWR_MSB:`ATB_PWR_LSB];
  assign tm_field  = atb_track_mode_t'(r_reg.track_ctrl[`ATB_TM_MSB:`ATB_TM_LSB]);
  assign tk_field  = r_reg.track_ctrl[`ATB_TK_MSB:`ATB_TK_LSB];
  assign pwr_cycles = 12'((pwr_field + 5'd1) * PWR_STEP_CYC);
  assign post_sar  = 5'(5'd2 << tk_field);
  // Burst with enable keeps the converter up; burst off does not use this
  assign keep_on = converter_enable;

  always_comb begin
    r_next = r_reg;
    r_next.conv_go = 1'b0;
    if (sfr_wr && sfr_addr == `ATB_TRACK_CTRL_ADDR) begin
      r_next.track_ctrl = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == `ATB_GAIN_ADDR) begin
      r_next.gain = sfr_wdata;
    end
    if (sfr_rd) begin
      case (sfr_addr)
        `ATB_TRACK_CTRL_ADDR: r_next.rdata = r_reg.track_ctrl;
        `ATB_GAIN_ADDR:       r_next.rdata = r_reg.gain;
        default:              r_next.rdata = 8'h00;
      endcase
    end
    case (r_reg.state)
      ATB_ST_IDLE: begin
        r_next.tracking = 1'b0;
        if (!burst_mode_enable) begin
          r_next.powered = converter_enable;
        end else if (keep_on) begin
          r_next.powered = 1'b1;
        end else begin
          r_next.powered = 1'b0;
        end
        if (conv_start && (converter_enable || burst_mode_enable)) begin
          if (burst_mode_enable && !r_reg.powered) begin
            r_next.powered = 1'b1;
            r_next.state = ATB_ST_POWERUP;
            r_next.count = pwr_cycles - 12'd1;
          end else if (tm_field == ATB_TM_POST) begin
            // Still up from the last conversion, so skip the delay but hold power
            r_next.powered = 1'b1;
            r_next.conv_go = 1'b1;
            r_next.state = ATB_ST_CONVERT;
          end else begin
            r_next.powered = 1'b1;
            r_next.tracking = 1'b1;
            r_next.state = ATB_ST_PRETRACK;
          end
        end
      end
      ATB_ST_POWERUP: begin
        if (r_reg.count == 12'd0) begin
          if (tm_field == ATB_TM_POST) begin
            r_next.conv_go = 1'b1;
            r_next.state = ATB_ST_CONVERT;
          end else begin
            r_next.tracking = 1'b1;
            r_next.state = ATB_ST_PRETRACK;
          end
        end else begin
          r_next.count = r_reg.count - 12'd1;
        end
      end
      ATB_ST_PRETRACK: begin
        // Pre-tracking has run for one system clock in this state
        r_next.tracking = 1'b0;
        r_next.conv_go = 1'b1;
        r_next.state = ATB_ST_CONVERT;
      end
      ATB_ST_CONVERT: begin
        if (conv_done) begin
          if (tm_field == ATB_TM_PRE) begin
            r_next.state = ATB_ST_IDLE;
          end else begin
            r_next.tracking = 1'b1;
            r_next.count = 12'(post_sar);
            r_next.state = ATB_ST_POST_SAR;
          end
        end
      end
      ATB_ST_POST_SAR: begin
        if (sar_clk_tick) begin
          if (r_reg.count == 12'd1) begin
            r_next.count = 12'(`ATB_POST_SYS_CYC - 1);
            r_next.state = ATB_ST_POST_SYS;
          end else begin
            r_next.count = r_reg.count - 12'd1;
          end
        end
      end
      ATB_ST_POST_SYS: begin
        if (r_reg.count == 12'd0) begin
          r_next.tracking = 1'b0;
          r_next.state = ATB_ST_IDLE;
        end else begin
          r_next.count = r_reg.count - 12'd1;
        end
      end
      default: r_next.state = ATB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg.track_ctrl <= `ATB_TRACK_CTRL_RESET;
      r_reg.gain       <= `ATB_GAIN_RESET;
      r_reg.state      <= ATB_ST_IDLE;
      r_reg.count      <= 12'h000;
      r_reg.rdata      <= 8'h00;
      r_reg.powered    <= 1'b0;
      r_reg.tracking   <= 1'b0;
      r_reg.conv_go    <= 1'b0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign sfr_rdata         = r_reg.rdata;
  assign converter_powered = r_reg.powered;
  assign tracking_active   = r_reg.tracking;
  assign conversion_go     = r_reg.conv_go;
  assign sequence_busy     = (r_reg.state != ATB_ST_IDLE);
  assign gain_value        = r_reg.gain;

  a_reset_value_ones: assert property (@(posedge clk_sys)
    $fell(sys_rst) |-> r_reg.track_ctrl == 8'hFF)
    else $error("tracking control not all ones after reset");

  a_burst_off_power: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && !burst_mode_enable && r_reg.state == ATB_ST_IDLE
      |=> converter_powered == $past(converter_enable))
    else $error("power not following enable with burst off");

  a_burst_stay_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && burst_mode_enable && converter_enable && converter_powered
      |=> converter_powered)
    else $error("converter dropped power while enabled in burst");

  a_burst_power_up: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && r_reg.state == ATB_ST_IDLE && burst_mode_enable && !converter_powered
      && conv_start |=> converter_powered && r_reg.state == ATB_ST_POWERUP)
    else $error("no power up on start in burst low power");

  a_powerup_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
    r_reg.state == ATB_ST_IDLE && r_next.state == ATB_ST_POWERUP && clk_en
      |=> r_reg.count == pwr_cycles - 12'd1)
    else $error("power up count wrong");

  a_post_no_pretrack: assert property (@(posedge clk_sys) disable iff (sys_rst)
    r_reg.state == ATB_ST_PRETRACK |-> tm_field != ATB_TM_POST)
    else $error("pre-tracking in post-tracking mode");

  a_post_sar_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && r_reg.state == ATB_ST_CONVERT && r_next.state == ATB_ST_POST_SAR
      |=> r_reg.count == 12'(post_sar))
    else $error("post-track count wrong");

  a_post_sys_tail: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && r_reg.state == ATB_ST_POST_SAR && r_next.state == ATB_ST_POST_SYS
      |=> r_reg.count == 12'd1)
    else $error("system clock tail count wrong");

  a_gain_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && sfr_wr && sfr_addr == `ATB_GAIN_ADDR |=> gain_value == $past(sfr_wdata))
    else $error("gain write lost");

  a_burst_low_power: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && burst_mode_enable && !converter_enable && !conv_start
      && r_reg.state == ATB_ST_IDLE |=> !converter_powered)
    else $error("converter left powered between burst conversions");

  a_pre_skips_post: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && r_reg.state == ATB_ST_CONVERT && conv_done && tm_field == ATB_TM_PRE
      |=> r_reg.state == ATB_ST_IDLE && !tracking_active)
    else $error("post-tracking ran in pre-tracking mode");

  a_go_one_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && conversion_go |=> !conversion_go)
    else $error("conversion start held longer than one cycle");
endmodule
`default_nettype wire

// ---- verif/atb_testbench.sv ----
// Self-checking bench for the tracking and burst power control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened power-up step keeps the run brief
  localparam int P = 3;
  logic       clk_sys = 0;
  logic       sys_rst = 1;
  logic       clk_en = 1;
  logic       sfr_wr = 0;
  logic       sfr_rd = 0;
  logic [7:0] sfr_addr = 0;
  logic [7:0] sfr_wdata = 0;
  logic [7:0] sfr_rdata;
  logic       converter_enable = 0;
  logic       burst_mode_enable = 0;
  logic       conv_start = 0;
  logic       sar_clk_tick = 0;
  logic       conv_done = 0;
  logic       converter_powered;
  logic       tracking_active;
  logic       conversion_go;
  logic       sequence_busy;
  logic [7:0] gain_value;
  logic [7:0] d;
  logic [7:0] v;
  int         n_errors = 0;
  int         n_checks = 0;

  atb_control #(.PWR_STEP_CYC(P)) atb_control_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .converter_enable(converter_enable), .burst_mode_enable(burst_mode_enable),
    .conv_start(conv_start), .sar_clk_tick(sar_clk_tick), .conv_done(conv_done),
    .converter_powered(converter_powered), .tracking_active(tracking_active),
    .conversion_go(conversion_go), .sequence_busy(sequence_busy),
    .gain_value(gain_value));

  always #4 clk_sys = ~clk_sys;

  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo(int n);
    if (n > 998) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] dt);
    @(posedge clk_sys);
    sfr_wr <= 1;
    sfr_addr <= a;
    sfr_wdata <= dt;
    @(posedge clk_sys);
    sfr_wr <= 0;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] dt);
    @(posedge clk_sys);
    sfr_rd <= 1;
    sfr_addr <= a;
    @(posedge clk_sys);
    sfr_rd <= 0;
    @(negedge clk_sys);
    dt = sfr_rdata;
  endtask

  // Burst conversion: power-up latency, tracking phases, post-track ticks
  task automatic conv(logic [3:0] pw, logic [1:0] tm, logic [1:0] tk, logic en);
    int n;
    int t;
    logic pre;
    @(posedge clk_sys);
    converter_enable <= en;
    burst_mode_enable <= 1;
    wr(8'hBA, {pw, tm, tk});
    @(negedge clk_sys);
    chk("powered idle", {7'h0, en}, {7'h0, converter_powered});
    @(posedge clk_sys);
    conv_start <= 1;
    @(posedge clk_sys);
    conv_start <= 0;
    n = 0;
    pre = 0;
    // Sample only at falling edges so the launch edge never races the check
    do begin
      @(negedge clk_sys);
      n++;
      pre |= tracking_active;
      if (en) chk("powered on", 8'h01, {7'h0, converter_powered});
    end while (conversion_go !== 1'b1 && n < 999);
    tmo(n);
    if (!en) chk("go delay", 8'((pw + 1) * P + 1 + (tm != 1)), 8'(n));
    else chk("go delay on", 8'(1 + (tm != 1)), 8'(n));
    chk("pre track", {7'h0, tm != 1}, {7'h0, pre});
    @(negedge clk_sys);
    chk("go pulse", 8'h00, {7'h0, conversion_go});
    repeat (3) @(posedge clk_sys);
    conv_done <= 1;
    @(posedge clk_sys);
    conv_done <= 0;
    @(negedge clk_sys);
    chk("post track", {7'h0, tm != 2}, {7'h0, tracking_active});
    t = 0;
    n = 0;
    while (tracking_active === 1'b1 && n < 999) begin
      @(posedge clk_sys);
      sar_clk_tick <= (n % 4 == 0);
      t += (n % 4 == 0);
      n++;
      @(negedge clk_sys);
    end
    tmo(n);
    sar_clk_tick <= 0;
    chk("sar ticks", (tm == 2) ? 8'h00 : 8'(2 << tk), 8'(t));
    repeat (3) @(negedge clk_sys);
    chk("powered end", {7'h0, en}, {7'h0, converter_powered});
    chk("busy end", 8'h00, {7'h0, sequence_busy});
  endtask

  initial begin
    void'($urandom(29270));
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    rd(8'hBA, d);
    chk("track ctrl reset", 8'hFF, d);
    chk("gain reset", 8'hFF, gain_value);
    rd(8'h55, d);
    chk("unmapped", 8'h00, d);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      wr(8'hBB, v);
      rd(8'hBB, d);
      chk("gain read", v, d);
      chk("gain out", v, gain_value);
    end
    // Frozen clock enable: a write must not land
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(8'hBB, ~v);
    clk_en <= 1'b1;
    rd(8'hBB, d);
    chk("gain frozen", v, d);
    chk("gain frozen out", v, gain_value);
    // Burst off: power must follow enable whatever the power-up field holds
    for (int i = 0; i < 4; i++) begin
      wr(8'hBA, 8'($urandom));
      @(posedge clk_sys);
      burst_mode_enable <= 0;
      converter_enable <= i[0];
      repeat (2) @(negedge clk_sys);
      chk("powered", {7'h0, i[0]}, {7'h0, converter_powered});
    end
    for (int k = 0; k < 4; k++)
      conv((k == 0) ? 4'h0 : (k == 3) ? 4'hF : 4'($urandom), 2'b01, 2'(k), 1'b0);
    for (int m = 0; m < 4; m++)
      conv(4'($urandom), 2'(m), 2'($urandom), m == 3);
    end_of_test();
  end
endmodule
`default_nettype wire
